// File: hdl/acr_regs.sv
// Accel config/status register bank: fill count, read port, state report,
// sampling setup and full-scale range, with an 8-byte sample FIFO behind the port.
// Assumes a synchronous register port and a producer that honours push_ready.
//
// Overview of operation
// - Upper six count bits at 0x25, rest zero
// - Low eight count bits at 0x24
// - Repeated reads of 0x26 pop successive bytes
// - Status message codes zero to four
// - Bit 5 flags invalid axis remapping
// - Bit 6 flags rate too low, 50Hz
// - Bit 7 flags rate too low, tap
// - Setup register fields; resets to 0xa8
// - Rate codes 1 to 12; others reserved
// - Continuous mode: OSR4, OSR2, normal only
// - Averaging mode: two to the n samples
// - Mode bit: zero averages, one filters
// - Range code picks 2/4/8/16g, resets 1
// - Count, port, status reset zero, read-only
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_regs #(
	parameter int CNT_W = 14,
	parameter int DEPTH = 8
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        push_valid,
	input  wire logic [7:0]  push_data,
	output logic             push_ready,
	input  wire logic [4:0]  status_msg,
	input  wire logic        remap_fault,
	input  wire logic        low_rate_feature_fault,
	input  wire logic        tap_rate_fault,
	output logic             perf_mode,
	output logic      [2:0]  bw_param,
	output logic      [3:0]  rate_code,
	output logic      [1:0]  range_code,
	output logic      [7:0]  avg_samples,
	output acr_pkg::acr_filt_t filter_sel,
	output logic             rate_code_legal,
	output logic             bw_param_legal
);
	localparam int LVL_W = $clog2(DEPTH + 1);

	acr_byte_if #(.WIDTH(8), .LVL_W(LVL_W)) fifo_if ();  // Link to the FIFO

	logic [7:0]       state_rpt_q;   // Internal status report
	logic [7:0]       sampling_q;    // Sampling setup
	logic [1:0]       range_q;       // Full-scale code
	logic [7:0]       rdata_q;       // Read data
	logic [7:0]       rdata_d;       // Read data next
	logic             rvalid_q;      // Read answer strobe
	logic [CNT_W-1:0] fill_count;    // Byte fill level
	logic             port_read;     // Read of the FIFO port
	logic             port_pop;      // Port read that removes a byte

	// FIFO behind the read port
	acr_byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_fifo (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.port   (fifo_if.fifo_side)
	);

	// Producer side of the FIFO; back-pressure goes straight out
	assign fifo_if.in_valid  = push_valid;
	assign fifo_if.in_data   = push_data;
	assign push_ready        = fifo_if.in_ready;

	// Decode of a read aimed at the data port
	assign port_read = reg_rd && (reg_addr == `ACR_ADDR_READ_PORT);
	assign port_pop  = ce && port_read && fifo_if.out_valid;
	assign fifo_if.out_ready = port_read;

	// Fill level widened to the reported count width
	assign fill_count = CNT_W'(fifo_if.level);

	// Status report mirrors the engine's flags and message
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_rpt_q <= `ACR_RST_STATE_RPT;
		end else if (ce) begin
			state_rpt_q[`ACR_MSG_MSB:0]      <= status_msg;
			state_rpt_q[`ACR_REMAP_BIT]      <= remap_fault;
			state_rpt_q[`ACR_LOWRATE_BIT]    <= low_rate_feature_fault;
			state_rpt_q[`ACR_TAP_FAULT_BIT]  <= tap_rate_fault;
		end
	end

	// Sampling setup register, fully writable
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sampling_q <= `ACR_RST_SAMPLING;
		end else if (ce && reg_wr && (reg_addr == `ACR_ADDR_SAMPLING)) begin
			sampling_q <= reg_wdata;
		end
	end

	// Full-scale register keeps only the range field
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			range_q <= 2'(`ACR_RST_FULLSCALE);
		end else if (ce && reg_wr && (reg_addr == `ACR_ADDR_FULLSCALE)) begin
			range_q <= reg_wdata[`ACR_RANGE_MSB:0];
		end
	end

	// Read data selection; writes to read-only offsets have no effect
	always_comb begin
		rdata_d = 8'h00;
		if (reg_addr == `ACR_ADDR_FILL_LOW) begin
			rdata_d = fill_count[7:0];
		end else if (reg_addr == `ACR_ADDR_FILL_HIGH) begin
			rdata_d = {2'b00, fill_count[CNT_W-1:8]};
		end else if (reg_addr == `ACR_ADDR_READ_PORT) begin
			rdata_d = fifo_if.out_valid ? fifo_if.out_data : `ACR_RST_PORT;
		end else if (reg_addr == `ACR_ADDR_STATE_RPT) begin
			rdata_d = state_rpt_q;
		end else if (reg_addr == `ACR_ADDR_SAMPLING) begin
			rdata_d = sampling_q;
		end else if (reg_addr == `ACR_ADDR_FULLSCALE) begin
			rdata_d = {6'b000000, range_q};
		end else begin
			// Unmapped offsets read zero
			rdata_d = 8'h00;
		end
	end

	// Registered read answer, one cycle after the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else if (ce) begin
			rvalid_q <= reg_rd;
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;

	// Configuration fields driven to the sensing path
	assign perf_mode  = sampling_q[`ACR_PERF_BIT];
	assign bw_param   = sampling_q[`ACR_BWP_MSB:`ACR_BWP_LSB];
	assign rate_code  = sampling_q[`ACR_ODR_MSB:`ACR_ODR_LSB];
	assign range_code = range_q;

	// Derived filter and averaging controls
	always_comb begin
		if (perf_mode == acr_pkg::ACR_MODE_CONT) begin
			avg_samples = 8'h01;
			case (bw_param)
				3'h0:    filter_sel = acr_pkg::ACR_FILT_OSR4;
				3'h1:    filter_sel = acr_pkg::ACR_FILT_OSR2;
				default: filter_sel = acr_pkg::ACR_FILT_NORMAL;
			endcase
		end else begin
			avg_samples = 8'h01 << bw_param;
			filter_sel  = acr_pkg::ACR_FILT_AVG;
		end
	end

	assign rate_code_legal = (rate_code >= `ACR_ODR_MIN) && (rate_code <= `ACR_ODR_MAX);
	assign bw_param_legal  = (perf_mode == acr_pkg::ACR_MODE_AVERAGE) ||
	                         (bw_param <= `ACR_BWP_CONT_MAX);

	// High count read shows zeros above the count
	AST_FILL_HIGH: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_rd && reg_addr == `ACR_ADDR_FILL_HIGH) |=>
		(reg_rvalid && reg_rdata[7:6] == 2'b00 &&
		 reg_rdata[5:0] == $past(fill_count[CNT_W-1:8])))
		else $error("high count read wrong");

	// Low count read returns the level at the request
	AST_FILL_LOW: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_rd && reg_addr == `ACR_ADDR_FILL_LOW) |=>
		(reg_rvalid && reg_rdata == $past(fill_count[7:0])))
		else $error("low count read wrong");

	// A port read of a non-empty FIFO returns the head and drops the level
	AST_PORT_POP: assert property (@(posedge clk) disable iff (!resetn)
		(port_pop && !(push_valid && push_ready)) |=>
		(reg_rdata == $past(fifo_if.out_data) &&
		 fifo_if.level == $past(fifo_if.level) - 1'b1))
		else $error("port read did not pop head byte");

	// Status read returns the message two cycles after its input
	AST_STATE_MSG: assert property (@(posedge clk) disable iff (!resetn)
		(ce && $past(ce) && reg_rd && reg_addr == `ACR_ADDR_STATE_RPT) |=>
		(reg_rdata[4:0] == $past(status_msg, 2)))
		else $error("status message not reported");

	// Remap fault reaches bit 5
	AST_REMAP: assert property (@(posedge clk) disable iff (!resetn)
		(ce && remap_fault) |=> state_rpt_q[5])
		else $error("remap fault not flagged");

	// Low rate fault reaches bit 6
	AST_LOW_RATE: assert property (@(posedge clk) disable iff (!resetn)
		(ce && low_rate_feature_fault) |=> state_rpt_q[6])
		else $error("low rate fault not flagged");

	// Tap rate fault reaches bit 7
	AST_TAP_RATE: assert property (@(posedge clk) disable iff (!resetn)
		(ce && tap_rate_fault) |=> state_rpt_q[7])
		else $error("tap rate fault not flagged");

	// Setup register holds its reset value at release
	AST_SETUP_RESET: assert property (@(posedge clk) disable iff (!resetn)
		$past(!resetn) |-> (sampling_q == 8'ha8 && range_q == 2'h1))
		else $error("setup reset value wrong");

	// Averaging count follows the bandwidth parameter
	AST_AVG: assert property (@(posedge clk) disable iff (!resetn)
		(!perf_mode) |-> (avg_samples[bw_param] && $onehot(avg_samples)))
		else $error("averaging count wrong");

	// Rate legality matches codes 1 to 12
	AST_RATE_LEGAL: assert property (@(posedge clk) disable iff (!resetn)
		rate_code_legal == (rate_code != 4'h0 && rate_code < 4'hd))
		else $error("rate legality wrong");

	// Full-scale read shows reserved bits as zero
	AST_RANGE_RD: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_rd && reg_addr == `ACR_ADDR_FULLSCALE) |=>
		(reg_rdata == {6'b000000, $past(range_q)}))
		else $error("range read wrong");

	// Frozen clock enable keeps the status report
	AST_STATE_RO: assert property (@(posedge clk) disable iff (!resetn)
		(!ce) |=> $stable(state_rpt_q))
		else $error("status changed while frozen");

	// Every accepted read raises the answer strobe one edge later
	AST_RD_STROBE: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_rd) |=> reg_rvalid)
		else $error("read not answered");

	// No answer strobe without an accepted read
	AST_NO_STROBE: assert property (@(posedge clk) disable iff (!resetn)
		(ce && !reg_rd) |=> !reg_rvalid)
		else $error("answer strobe without read");

	// A port read of an empty FIFO returns zero and pops nothing
	AST_EMPTY_PORT: assert property (@(posedge clk) disable iff (!resetn)
		(ce && port_read && !fifo_if.out_valid && !push_valid) |=>
		(reg_rdata == 8'h00 && fifo_if.level == '0))
		else $error("empty port read wrong");

	// A setup write lands in all three fields
	AST_SETUP_WR: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_wr && reg_addr == `ACR_ADDR_SAMPLING) |=>
		({perf_mode, bw_param, rate_code} == $past(reg_wdata)))
		else $error("setup write lost");

	// A full-scale write keeps only the range code
	AST_RANGE_WR: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_wr && reg_addr == `ACR_ADDR_FULLSCALE) |=>
		(range_code == $past(reg_wdata[1:0])))
		else $error("range write lost");

	// Writes to read-only offsets leave the writable registers alone
	AST_RO_WRITE: assert property (@(posedge clk) disable iff (!resetn)
		(ce && reg_wr && (reg_addr == `ACR_ADDR_FILL_LOW ||
		 reg_addr == `ACR_ADDR_FILL_HIGH || reg_addr == `ACR_ADDR_READ_PORT ||
		 reg_addr == `ACR_ADDR_STATE_RPT)) |=>
		($stable(sampling_q) && $stable(range_q)))
		else $error("read-only write changed a register");

	// Continuous mode maps legal codes straight to the filter choice
	AST_FILT_CONT: assert property (@(posedge clk) disable iff (!resetn)
		(perf_mode && bw_param <= `ACR_BWP_CONT_MAX) |->
		(filter_sel == acr_pkg::acr_filt_t'(bw_param[1:0]) && avg_samples == 8'h01))
		else $error("continuous filter choice wrong");

	// Mode bit low always selects the averaging path
	AST_MODE_AVG: assert property (@(posedge clk) disable iff (!resetn)
		(!perf_mode) |-> (filter_sel == acr_pkg::ACR_FILT_AVG))
		else $error("averaging path not selected");

endmodule : acr_regs

// File: hdl/acr_map.svh
// Register offsets, field positions and reset values of the accel config/status bank.
// Assumes an 8-bit register address space and 8-bit register data.
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

// Register offsets
`define ACR_ADDR_FILL_LOW   8'h24
`define ACR_ADDR_FILL_HIGH  8'h25
`define ACR_ADDR_READ_PORT  8'h26
`define ACR_ADDR_STATE_RPT  8'h2a
`define ACR_ADDR_SAMPLING   8'h40
`define ACR_ADDR_FULLSCALE  8'h41

// Reset values
`define ACR_RST_FILL        8'h00
`define ACR_RST_PORT        8'h00
`define ACR_RST_STATE_RPT   8'h00
`define ACR_RST_SAMPLING    8'ha8
`define ACR_RST_FULLSCALE   8'h01

// Field positions in the sampling setup register
`define ACR_PERF_BIT        7
`define ACR_BWP_MSB         6
`define ACR_BWP_LSB         4
`define ACR_ODR_MSB         3
`define ACR_ODR_LSB         0

// Field positions in the state report register
`define ACR_TAP_FAULT_BIT   7
`define ACR_LOWRATE_BIT     6
`define ACR_REMAP_BIT       5
`define ACR_MSG_MSB         4

// Full-scale range field and high fill-count field width
`define ACR_RANGE_MSB       1
`define ACR_FILL_HIGH_MSB   5

// Legal code limits
`define ACR_ODR_MIN         4'h1
`define ACR_ODR_MAX         4'hc
`define ACR_BWP_CONT_MAX    3'h2

`endif

// File: hdl/acr_pkg.sv
// Types shared by the accel config/status bank.
// Assumes nothing beyond a SystemVerilog compiler.
package acr_pkg;

	// Internal status message codes
	typedef enum logic [4:0] {
		ACR_MSG_NOT_INIT = 5'h00,
		ACR_MSG_INIT_OK  = 5'h01,
		ACR_MSG_INIT_ERR = 5'h02,
		ACR_MSG_DRV_ERR  = 5'h03,
		ACR_MSG_STOPPED  = 5'h04
	} acr_msg_t;

	// Filter performance mode
	typedef enum logic {
		ACR_MODE_AVERAGE = 1'b0,
		ACR_MODE_CONT    = 1'b1
	} acr_perf_t;

	// Full-scale range selection
	typedef enum logic [1:0] {
		ACR_RANGE_2G  = 2'h0,
		ACR_RANGE_4G  = 2'h1,
		ACR_RANGE_8G  = 2'h2,
		ACR_RANGE_16G = 2'h3
	} acr_range_t;

	// Continuous filter selection, or averaging when not in continuous mode
	typedef enum logic [1:0] {
		ACR_FILT_OSR4   = 2'h0,
		ACR_FILT_OSR2   = 2'h1,
		ACR_FILT_NORMAL = 2'h2,
		ACR_FILT_AVG    = 2'h3
	} acr_filt_t;

endpackage : acr_pkg

// File: hdl/acr_byte_if.sv
// Byte stream carrier between the register bank and its sample FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface acr_byte_if #(
	parameter int WIDTH = 8,
	parameter int LVL_W = 4
);
	logic             in_valid;   // Producer offers a byte
	logic             in_ready;   // FIFO has room
	logic [WIDTH-1:0] in_data;    // Byte being written
	logic             out_valid;  // FIFO holds a byte
	logic             out_ready;  // Reader takes the head byte
	logic [WIDTH-1:0] out_data;   // Head byte
	logic [LVL_W-1:0] level;      // Bytes stored

	// FIFO end
	modport fifo_side (
		input  in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data, level
	);
	// Register bank end
	modport user_side (
		output in_valid, in_data, out_ready,
		input  in_ready, out_valid, out_data, level
	);
endinterface : acr_byte_if

// File: hdl/acr_byte_fifo.sv
// Small flip-flop FIFO holding sample bytes until the host reads them out.
// Assumes one clock, asynchronous active-low reset and a freezing clock enable.
`timescale 1ns/1ps
module acr_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8,
	parameter int LVL_W = $clog2(DEPTH + 1)
) (
	input wire logic    clk,
	input wire logic    resetn,
	input wire logic    ce,
	acr_byte_if.fifo_side port
);
	localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);
	localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
	logic [IDX_W-1:0] wr_idx_q;       // Next slot to fill
	logic [IDX_W-1:0] rd_idx_q;       // Head slot
	logic [LVL_W-1:0] level_q;        // Occupancy
	logic             push;           // Byte accepted this cycle
	logic             pop;            // Byte removed this cycle

	// Honest full and empty
	assign port.in_ready  = (level_q != FULL_LVL);
	assign port.out_valid = (level_q != '0);
	assign port.out_data  = mem_q[rd_idx_q];
	assign port.level     = level_q;
	assign push = ce && port.in_valid && port.in_ready;
	assign pop  = ce && port.out_ready && port.out_valid;

	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_idx_q] <= port.in_data;
		end
	end

	// Pointers and level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_idx_q <= '0;
			rd_idx_q <= '0;
			level_q  <= '0;
		end else begin
			if (push) begin
				wr_idx_q <= (wr_idx_q == LAST_IDX) ? '0 : wr_idx_q + 1'b1;
			end
			if (pop) begin
				rd_idx_q <= (rd_idx_q == LAST_IDX) ? '0 : rd_idx_q + 1'b1;
			end
			if (push && !pop) begin
				level_q <= level_q + 1'b1;
			end else if (pop && !push) begin
				level_q <= level_q - 1'b1;
			end
		end
	end

	// Level never passes the depth
	AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!resetn)
		level_q <= FULL_LVL) else $error("fifo level above depth");

endmodule : acr_byte_fifo

// File: verification/acr_host_model.sv
// Host model driving the register port of the accel config/status bank.
// Assumes requests are taken on a rising clk edge and answered one edge later.
`timescale 1ns/1ps
module acr_host_model (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_rvalid
);
	// Idle request lines from time zero
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'b0;
		reg_wdata = 8'h5a;
		reg_rd    = 1'b0;
	end

	// No code check: callers may hand over unsupported codes
	// One write, held until the taking edge has passed
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		reg_addr  = addr;
		reg_wdata = data;
		reg_wr    = 1'b1;
		@(posedge clk);
		#1;
		reg_wr    = 1'b0;
		reg_wdata = ~data;  // Released data line no longer shows the last value
	endtask : wr

	// Burst at one address
	// Back-to-back reads; each edge returns {rvalid, rdata} of the read it took
	task automatic rd_burst(input logic [7:0] addr, input int n, output logic [8:0] q[$]);
		q = {};
		@(posedge clk);
		#1;
		reg_addr = addr;
		reg_rd   = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			if (i == n - 1) begin
				reg_rd = 1'b0;
			end
			q.push_back({reg_rvalid, reg_rdata});
		end
	endtask : rd_burst
endmodule : acr_host_model

// File: verification/acr_regs_bench.sv
// Self-checking bench of the accel config/status bank against a queue model.
// Assumes the host model and the design files are compiled before it.
`timescale 1ns/1ps
`include "acr_map.svh"
module acr_regs_bench;
	logic               clk;
	logic               resetn;
	logic               ce;
	logic [7:0]         reg_addr, reg_wdata, reg_rdata, avg_samples;
	logic               reg_wr, reg_rd, reg_rvalid;
	logic               push_valid, push_ready;
	logic [7:0]         push_data;
	logic [4:0]         status_msg;
	logic               remap_fault, low_rate_feature_fault, tap_rate_fault;
	logic               perf_mode, rate_code_legal, bw_param_legal;
	logic [2:0]         bw_param;
	logic [3:0]         rate_code;
	logic [1:0]         range_code;
	acr_pkg::acr_filt_t filter_sel;
	int                 errors, check_count, cycles, seed_val, n;
	logic [7:0]         fq[$];           // Model FIFO contents
	logic [7:0]         setup, range, st; // Model registers
	logic [2:0]         flt;
	localparam int      FIFO_DEPTH = 8;   // Bytes the design buffers
	logic [7:0]         ro_addr[5] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h30}; // Read-only, unmapped

	acr_regs i_acr_regs (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .push_valid(push_valid), .push_data(push_data),
		.push_ready(push_ready), .status_msg(status_msg), .remap_fault(remap_fault),
		.low_rate_feature_fault(low_rate_feature_fault), .tap_rate_fault(tap_rate_fault),
		.perf_mode(perf_mode), .bw_param(bw_param), .rate_code(rate_code),
		.range_code(range_code), .avg_samples(avg_samples), .filter_sel(filter_sel),
		.rate_code_legal(rate_code_legal), .bw_param_legal(bw_param_legal));

	acr_host_model i_acr_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			end_of_test();
		end
	end

	// Compare one value and count it
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Model answer of one read; the port read pops the model FIFO
	function automatic logic [7:0] exp_rd(input logic [7:0] a);
		case (a)
			`ACR_ADDR_FILL_LOW:  return 8'(fq.size());
			`ACR_ADDR_FILL_HIGH: return {2'h0, 6'(fq.size() >> 8)};
			`ACR_ADDR_READ_PORT: return (fq.size() > 0) ? fq.pop_front() : 8'h00;
			`ACR_ADDR_STATE_RPT: return st;
			`ACR_ADDR_SAMPLING:  return setup;
			`ACR_ADDR_FULLSCALE: return range;
			default:             return 8'h00;
		endcase
	endfunction : exp_rd

	// Burst read compared against the model
	task automatic rd_chk(input logic [7:0] a, input int cnt);
		logic [8:0] q[$];
		i_acr_host_model.rd_burst(a, cnt, q);
		foreach (q[i]) begin
			check("rvalid", {7'h0, q[i][8]}, 8'h01);
			check("rdata", q[i][7:0], exp_rd(a));
		end
	endtask : rd_chk

	// Write through the host and mirror it in the model
	task automatic hw(input logic [7:0] a, input logic [7:0] d);
		i_acr_host_model.wr(a, d);
		if (ce && a == `ACR_ADDR_SAMPLING) setup = d;
		if (ce && a == `ACR_ADDR_FULLSCALE) range = {6'h0, d[1:0]};
	endtask : hw

	// Every mapped register plus one unmapped address
	task automatic rd_all();
		logic [7:0] al[7] = '{8'h24, 8'h25, 8'h26, 8'h2a, 8'h40, 8'h41, 8'h30};
		foreach (al[i]) rd_chk(al[i], 1);
	endtask : rd_all

	// Reset held for 20 cycles, model back to reset values
	task automatic do_reset();
		resetn = 1'b0;
		fq = {};
		setup = `ACR_RST_SAMPLING;
		range = `ACR_RST_FULLSCALE;
		repeat (20) @(posedge clk);
		#1;
		resetn = 1'b1;
	endtask : do_reset

	// Print the counts and the verdict, then stop
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	// Main sequence
	initial begin
		ce = 1'b1;
		push_valid = 1'b0;
		push_data = 8'h00;
		status_msg = 5'h00;
		{tap_rate_fault, low_rate_feature_fault, remap_fault} = 3'h0;
		st = 8'h00;
		seed_val = $urandom(32'hd44c);
		do_reset();
		rd_all();
		check("avg", avg_samples, 8'h01);
		check("filt", {6'h0, filter_sel}, 8'h02);
		// Writes to read-only places and reserved range bits
		foreach (ro_addr[i]) hw(ro_addr[i], 8'hff);
		hw(`ACR_ADDR_FULLSCALE, 8'hff);
		rd_all();
		for (int r = 0; r < 4; r++) begin
			hw(`ACR_ADDR_FULLSCALE, {6'($urandom), 2'(r)});
			check("range", {6'h0, range_code}, 8'(r));
			rd_chk(`ACR_ADDR_FULLSCALE, 1);
		end
		// Frozen clock enable drops a write
		ce = 1'b0;
		hw(`ACR_ADDR_FULLSCALE, 8'h00);
		ce = 1'b1;
		rd_chk(`ACR_ADDR_FULLSCALE, 1);
		// Host writes only supported rates
		// Every legal rate code; every averaging depth and filter selection
		for (int k = 0; k < 12; k++) begin
			hw(`ACR_ADDR_SAMPLING, (k < 8) ? {1'b0, 3'(k), 4'(k + 1)}
				: {1'b1, 3'((k < 11) ? k - 8 : $urandom % 3), 4'(k + 1)});
			check("perf", {7'h0, perf_mode}, {7'h0, setup[7]});
			check("bwp", {5'h0, bw_param}, {5'h0, setup[6:4]});
			check("rate", {4'h0, rate_code}, 8'(k + 1));
			check("legal", {6'h0, rate_code_legal, bw_param_legal}, 8'h03);
			check("avg", avg_samples, setup[7] ? 8'h01 : 8'(1 << setup[6:4]));
			check("filt", {6'h0, filter_sel}, setup[7] ? {6'h0, setup[5:4]} : 8'h03);
			rd_chk(`ACR_ADDR_SAMPLING, 1);
		end
		// Status message codes with random fault flags
		for (int m = 0; m < 5; m++) begin
			flt = 3'($urandom);
			status_msg = 5'(m);
			{tap_rate_fault, low_rate_feature_fault, remap_fault} = flt;
			st = {flt, 5'(m)};
			rd_chk(`ACR_ADDR_STATE_RPT, 1);
		end
		// Fill the FIFO until it refuses, then drain past empty
		n = 0;
		for (int i = 0; i < 10; i++) begin
			push_valid = 1'b1;
			push_data = 8'($urandom);
			check("push_ready", {7'h0, push_ready}, {7'h0, fq.size() < FIFO_DEPTH});
			if (push_ready === 1'b1) n++;
			if (fq.size() < FIFO_DEPTH) fq.push_back(push_data);
			@(posedge clk);
			#1;
		end
		push_valid = 1'b0;
		check("pushes", 8'(n), 8'(FIFO_DEPTH));
		rd_chk(`ACR_ADDR_FILL_LOW, 1);
		rd_chk(`ACR_ADDR_FILL_HIGH, 1);
		rd_chk(`ACR_ADDR_READ_PORT, 9);
		rd_chk(`ACR_ADDR_FILL_LOW, 2);
		// Second reset in mid-run
		hw(`ACR_ADDR_SAMPLING, 8'h17);
		do_reset();
		rd_all();
		end_of_test();
	end
endmodule : acr_regs_bench
